// File: core/port_phy_control_reg.v
// Control register of the second copper port's transceiver, Avalon-MM slave.
// Assumes negotiation results and indicator drive come from SYS_CLK logic.
//
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "port_phy_defs.vh"
module port_phy_control_reg #(
  parameter LED_COUNT = 4
) (
  input  wire                 SYS_CLK,
  input  wire                 RSTN,
  input  wire [7:0]           AVS_ADDRESS,
  input  wire                 AVS_READ,
  input  wire                 AVS_WRITE,
  input  wire [31:0]          AVS_WRITEDATA,
  input  wire [3:0]           AVS_BYTEENABLE,
  output reg  [31:0]          AVS_READDATA,
  output reg                  AVS_WAITREQUEST,
  input  wire [LED_COUNT-1:0] INDICATOR_DRIVE,
  input  wire                 NEG_DONE,
  input  wire                 NEG_FAILED,
  input  wire                 NEG_SPEED_100,
  input  wire                 NEG_FULL_DUPLEX,
  output wire                 PORT_TWO_INDICATOR_0,
  output wire                 PORT_TWO_INDICATOR_1,
  output wire                 PORT_TWO_INDICATOR_2,
  output wire                 PORT_TWO_INDICATOR_3,
  output reg                  TX_DISABLE,
  output reg                  RENEGOTIATE_REQUEST,
  output reg                  POWER_DOWN,
  output reg                  AUTO_CROSSOVER_OFF,
  output reg                  FORCE_CROSSED_WIRING,
  output reg                  FAR_END_LOOPBACK,
  output reg                  NEG_ENABLE,
  output reg                  LINK_SPEED_100,
  output reg                  LINK_FULL_DUPLEX,
  output reg                  ADVERTISE_PAUSE,
  output reg                  ADVERTISE_100_FULL,
  output reg                  ADVERTISE_100_HALF,
  output reg                  ADVERTISE_10_FULL,
  output reg                  ADVERTISE_10_HALF
);

  // Reset release synchroniser
  reg         rst_meta_reg;
  reg         rst_sync_reg;
  wire        rst_n;

  reg  [15:0] ctrl_reg;
  reg  [15:0] ctrl_next;
  reg  [31:0] rdata_next;
  reg         wait_next;
  reg  [1:0]  bus_state_reg;
  reg  [1:0]  bus_state_next;
  wire        req;
  wire        commit;
  wire        ctrl_hit;
  wire [15:0] stat_word;
  reg         speed_next;
  reg         duplex_next;
  reg         crossed_next;
  wire [LED_COUNT-1:0] led_out;

  // Bus phases, one-hot
  localparam BUS_IDLE   = 2'b01;
  localparam BUS_ANSWER = 2'b10;

  // Word index match on a byte address; low two bits ignored
  function hit;
    input [7:0] addr;
    input [5:0] index;
    begin
      hit = (addr[7:2] == index);
    end
  endfunction

  // Merge the two low byte lanes into a 16-bit register
  function [15:0] lane_merge;
    input [15:0] old;
    input [31:0] data;
    input [3:0]  be;
    begin
      lane_merge = old;
      if (be[0]) begin
        lane_merge[7:0] = data[7:0];
      end
      if (be[1]) begin
        lane_merge[15:8] = data[15:8];
      end
    end
  endfunction

  // Read multiplexer; unmapped places answer zero
  function [31:0] read_word;
    input [7:0]  addr;
    input [15:0] ctrl;
    input [15:0] stat;
    begin
      if (hit(addr, `CTRL_INDEX)) begin
        read_word = {16'h0000, ctrl};
      end else if (hit(addr, `STAT_INDEX)) begin
        read_word = {16'h0000, stat};
      end else begin
        read_word = 32'h0000_0000;
      end
    end
  endfunction

  // Status word; bits above the flags read zero
  function [15:0] status_pack;
    input speed;
    input duplex;
    input crossed;
    input pending;
    input done;
    input failed;
    begin
      status_pack                  = 16'h0000;
      status_pack[`ST_SPEED_100]   = speed;
      status_pack[`ST_FULL_DUPLEX] = duplex;
      status_pack[`ST_CROSSED]     = crossed;
      status_pack[`ST_RENEG_PEND]  = pending;
      status_pack[`ST_NEG_DONE]    = done;
      status_pack[`ST_NEG_FAILED]  = failed;
    end
  endfunction

  always @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  assign rst_n = rst_sync_reg;

  // Bus handshake: one wait cycle per access, then the answer
  assign req      = AVS_READ | AVS_WRITE;
  assign commit   = req & ~AVS_WAITREQUEST;
  assign ctrl_hit = hit(AVS_ADDRESS, `CTRL_INDEX);

  // Answer phase is one cycle; a request still held is taken again two cycles later
  always @* begin
    bus_state_next = bus_state_reg;
    wait_next      = 1'b1;
    case (bus_state_reg)
      BUS_IDLE: begin
        if (req) begin
          bus_state_next = BUS_ANSWER;
          wait_next      = 1'b0;
        end
      end
      BUS_ANSWER: begin
        bus_state_next = BUS_IDLE;
      end
      default: begin
        bus_state_next = BUS_IDLE;
      end
    endcase
  end

  always @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      bus_state_reg <= BUS_IDLE;
    end else begin
      bus_state_reg <= bus_state_next;
    end
  end

  // Read data is captured as waitrequest drops and held after
  always @* begin
    rdata_next = AVS_READDATA;
    if (AVS_READ && AVS_WAITREQUEST) begin
      rdata_next = read_word(AVS_ADDRESS, ctrl_reg, stat_word);
    end
  end

  always @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA    <= 32'h0000_0000;
    end else begin
      AVS_WAITREQUEST <= wait_next;
      AVS_READDATA    <= rdata_next;
    end
  end

  // Control register; restart bit clears itself once issued
  always @* begin
    ctrl_next = ctrl_reg;
    if (ctrl_reg[`BIT_RENEG]) begin
      ctrl_next[`BIT_RENEG] = 1'b0;
    end
    // A new write after the clear wins, so no restart is lost
    if (commit && AVS_WRITE && ctrl_hit) begin
      ctrl_next = lane_merge(ctrl_reg, AVS_WRITEDATA, AVS_BYTEENABLE);
    end
  end

  always @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= `CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // Effective link mode
  always @* begin
    speed_next  = NEG_SPEED_100;
    duplex_next = NEG_FULL_DUPLEX;
    if (!ctrl_reg[`BIT_NEG_EN]) begin
      speed_next  = ctrl_reg[`BIT_FORCE_100];
      duplex_next = ctrl_reg[`BIT_FORCE_FULL];
    end else if (NEG_FAILED) begin
      // Speed still follows what the line detected
      duplex_next = ctrl_reg[`BIT_FORCE_FULL];
    end
  end

  always @* begin
    crossed_next = 1'b0;
    if (ctrl_reg[`BIT_XOVER_OFF]) begin
      crossed_next = ctrl_reg[`BIT_FORCE_CROSS];
    end
  end

  assign stat_word = status_pack(LINK_SPEED_100,
                                 LINK_FULL_DUPLEX,
                                 FORCE_CROSSED_WIRING,
                                 ctrl_reg[`BIT_RENEG],
                                 NEG_DONE,
                                 NEG_FAILED);

  // Transceiver controls, all registered
  always @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      TX_DISABLE           <= 1'b0;
      RENEGOTIATE_REQUEST  <= 1'b0;
      POWER_DOWN           <= 1'b0;
      AUTO_CROSSOVER_OFF   <= 1'b0;
      FORCE_CROSSED_WIRING <= 1'b0;
      FAR_END_LOOPBACK     <= 1'b0;
      NEG_ENABLE           <= 1'b1;
      LINK_SPEED_100       <= 1'b0;
      LINK_FULL_DUPLEX     <= 1'b0;
    end else begin
      TX_DISABLE           <= ctrl_reg[`BIT_TX_OFF];
      RENEGOTIATE_REQUEST  <= ctrl_reg[`BIT_RENEG];
      POWER_DOWN           <= ctrl_reg[`BIT_POWER_DOWN];
      AUTO_CROSSOVER_OFF   <= ctrl_reg[`BIT_XOVER_OFF];
      FORCE_CROSSED_WIRING <= crossed_next;
      FAR_END_LOOPBACK     <= ctrl_reg[`BIT_FAR_LOOP];
      NEG_ENABLE           <= ctrl_reg[`BIT_NEG_EN];
      LINK_SPEED_100       <= speed_next;
      LINK_FULL_DUPLEX     <= duplex_next;
    end
  end

  // Advertised abilities; clear withholds each one
  always @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      ADVERTISE_PAUSE    <= 1'b1;
      ADVERTISE_100_FULL <= 1'b1;
      ADVERTISE_100_HALF <= 1'b1;
      ADVERTISE_10_FULL  <= 1'b1;
      ADVERTISE_10_HALF  <= 1'b1;
    end else begin
      ADVERTISE_PAUSE    <= ctrl_reg[`BIT_ADV_PAUSE];
      ADVERTISE_100_FULL <= ctrl_reg[`BIT_ADV_100F];
      ADVERTISE_100_HALF <= ctrl_reg[`BIT_ADV_100H];
      ADVERTISE_10_FULL  <= ctrl_reg[`BIT_ADV_10F];
      ADVERTISE_10_HALF  <= ctrl_reg[`BIT_ADV_10H];
    end
  end

  // Indicator pins, blanked high
  indicator_blank #(
    .WIDTH (LED_COUNT)
  ) u_indicator_blank (
    .clk     (SYS_CLK),
    .rst_n   (rst_n),
    .blank   (ctrl_reg[`BIT_LED_BLANK]),
    .drive   (INDICATOR_DRIVE),
    .led_reg (led_out)
  );

  assign PORT_TWO_INDICATOR_0 = led_out[0];
  assign PORT_TWO_INDICATOR_1 = led_out[1];
  assign PORT_TWO_INDICATOR_2 = led_out[2];
  assign PORT_TWO_INDICATOR_3 = led_out[3];

endmodule // port_phy_control_reg

// File: shared/port_phy_defs.vh
// Constants for the second port's transceiver control register block.
// Included by the register block and its checker; holds definitions only.
`ifndef PORT_PHY_DEFS_VH
`define PORT_PHY_DEFS_VH

// Register indexes; byte address is four times the index
`define CTRL_INDEX        6'h02
`define STAT_INDEX        6'h04

// Control register field positions
`define BIT_LED_BLANK     15
`define BIT_TX_OFF        14
`define BIT_RENEG         13
`define BIT_SPARE         12
`define BIT_POWER_DOWN    11
`define BIT_XOVER_OFF     10
`define BIT_FORCE_CROSS   9
`define BIT_FAR_LOOP      8
`define BIT_NEG_EN        7
`define BIT_FORCE_100     6
`define BIT_FORCE_FULL    5
`define BIT_ADV_PAUSE     4
`define BIT_ADV_100F      3
`define BIT_ADV_100H      2
`define BIT_ADV_10F       1
`define BIT_ADV_10H       0

// Status register field positions
`define ST_SPEED_100      0
`define ST_FULL_DUPLEX    1
`define ST_CROSSED        2
`define ST_RENEG_PEND     3
`define ST_NEG_DONE       4
`define ST_NEG_FAILED     5

// Reset values
`define CTRL_RESET        16'h009f
`define INDICATOR_RESET   4'hf

`endif

// File: core/indicator_blank.v
// Registered drive of the port's four indicator pins.
// Assumes drive and blank come from logic on the same clock.
`timescale 1ns/1ps
module indicator_blank #(
  parameter WIDTH = 4
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             blank,
  input  wire [WIDTH-1:0] drive,
  output reg  [WIDTH-1:0] led_reg
);

  // Pins idle high, which is also the dark level
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      led_reg <= {WIDTH{1'b1}};
    end else if (blank) begin
      led_reg <= {WIDTH{1'b1}};
    end else begin
      led_reg <= drive;
    end
  end

endmodule // indicator_blank

// File: tb/port_phy_control_reg_properties.sv
// Checker for the port transceiver control register block.
// Assumes it is bound to the block and sees only its ports.
`timescale 1ns/1ps
`include "port_phy_defs.vh"
module port_phy_control_reg_properties (
  input wire        SYS_CLK,
  input wire        RSTN,
  input wire [7:0]  AVS_ADDRESS,
  input wire        AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  input wire [3:0]  AVS_BYTEENABLE,
  input wire        AVS_WAITREQUEST,
  input wire        PORT_TWO_INDICATOR_0,
  input wire        PORT_TWO_INDICATOR_1,
  input wire        PORT_TWO_INDICATOR_2,
  input wire        PORT_TWO_INDICATOR_3,
  input wire        TX_DISABLE,
  input wire        RENEGOTIATE_REQUEST,
  input wire        AUTO_CROSSOVER_OFF,
  input wire        FORCE_CROSSED_WIRING,
  input wire        FAR_END_LOOPBACK,
  input wire        NEG_ENABLE
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);
  // Completed writes to each lane of the control register
  wire ok = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS[7:2] == `CTRL_INDEX;
  wire hi = ok && AVS_BYTEENABLE[1];
  wire lo = ok && AVS_BYTEENABLE[0];
  wire [15:0] d = AVS_WRITEDATA[15:0];
  AST_LED_BLANK: assert property (hi && d[15] |-> ##3
    PORT_TWO_INDICATOR_0 && PORT_TWO_INDICATOR_1 && PORT_TWO_INDICATOR_2
    && PORT_TWO_INDICATOR_3) else $error("indicators not blanked");
  AST_TX_OFF: assert property (hi |-> ##2 TX_DISABLE == $past(d[14], 2))
    else $error("transmit disable wrong");
  AST_RENEG: assert property (hi && d[13] |-> ##2 RENEGOTIATE_REQUEST
    ##1 !RENEGOTIATE_REQUEST) else $error("restart pulse wrong");
  AST_XOVER: assert property (hi |-> ##2
    AUTO_CROSSOVER_OFF == $past(d[10], 2))
    else $error("crossover off wrong");
  AST_CROSS: assert property (hi |-> ##2 FORCE_CROSSED_WIRING ==
    ($past(d[10], 2) && $past(d[9], 2))) else $error("forced crossing wrong");
  AST_LOOP: assert property (hi |-> ##2
    FAR_END_LOOPBACK == $past(d[8], 2))
    else $error("loopback wrong");
  AST_NEG: assert property (lo |-> ##2 NEG_ENABLE == $past(d[7], 2))
    else $error("negotiation enable wrong");
  AST_WAIT: assert property (AVS_WRITE && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("write not answered");
endmodule // port_phy_control_reg_properties

bind port_phy_control_reg port_phy_control_reg_properties u_props (.*);

// File: tb/neg_engine_model.sv
// Far-side model: negotiation engine and indicator drive of the port.
// Assumes the block's clock; results settle one edge after a mode change.
`timescale 1ns/1ps
module neg_engine_model (
  input  wire       SYS_CLK,
  input  wire       RSTN,
  input  wire       fail_mode,
  output reg        NEG_DONE,
  output reg        NEG_FAILED,
  output reg        NEG_SPEED_100,
  output reg        NEG_FULL_DUPLEX,
  output reg  [3:0] INDICATOR_DRIVE
);
  // Failed link still reports 10 Mbit line detect, full duplex
  always @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      {NEG_DONE, NEG_FAILED, NEG_SPEED_100, NEG_FULL_DUPLEX} <= 4'h0;
      INDICATOR_DRIVE <= 4'h5;
    end else begin
      {NEG_DONE, NEG_FAILED, NEG_SPEED_100, NEG_FULL_DUPLEX} <=
        fail_mode ? 4'h5 : 4'hb;
      INDICATOR_DRIVE <= ~INDICATOR_DRIVE;
    end
  end
endmodule // neg_engine_model

// File: tb/port_phy_control_reg_tb_top.sv
// Testbench for the port transceiver control register block.
// Assumes a 20 MHz clock and the far-side negotiation model.
`timescale 1ns/1ps
module port_phy_control_reg_tb_top;
  reg         SYS_CLK = 1'b0;
  reg         RSTN = 1'b0;
  reg         AVS_READ = 1'b0;
  reg         AVS_WRITE = 1'b0;
  reg  [7:0]  AVS_ADDRESS = 8'h00;
  reg  [31:0] AVS_WRITEDATA = 32'h0;
  reg  [3:0]  AVS_BYTEENABLE = 4'h3;
  reg         fail_mode = 1'b0;
  wire [31:0] AVS_READDATA;
  wire        AVS_WAITREQUEST, NEG_DONE, NEG_FAILED, NEG_SPEED_100;
  wire        NEG_FULL_DUPLEX, TX_DISABLE, RENEGOTIATE_REQUEST, POWER_DOWN;
  wire        AUTO_CROSSOVER_OFF, FORCE_CROSSED_WIRING, FAR_END_LOOPBACK;
  wire        NEG_ENABLE, LINK_SPEED_100, LINK_FULL_DUPLEX, ADVERTISE_PAUSE;
  wire        ADVERTISE_100_FULL, ADVERTISE_100_HALF, ADVERTISE_10_FULL;
  wire        ADVERTISE_10_HALF, PORT_TWO_INDICATOR_0, PORT_TWO_INDICATOR_1;
  wire        PORT_TWO_INDICATOR_2, PORT_TWO_INDICATOR_3;
  wire [3:0]  INDICATOR_DRIVE;
  wire [3:0]  ind = {PORT_TWO_INDICATOR_3, PORT_TWO_INDICATOR_2,
                     PORT_TWO_INDICATOR_1, PORT_TWO_INDICATOR_0};
  wire [12:0] outs = {TX_DISABLE, POWER_DOWN, AUTO_CROSSOVER_OFF,
    FORCE_CROSSED_WIRING, FAR_END_LOOPBACK, NEG_ENABLE, LINK_SPEED_100,
    LINK_FULL_DUPLEX, ADVERTISE_PAUSE, ADVERTISE_100_FULL,
    ADVERTISE_100_HALF, ADVERTISE_10_FULL, ADVERTISE_10_HALF};
  integer     bad_count = 0;
  integer     num_checks = 0;
  integer     cyc = 0;
  reg  [15:0] rd;
  port_phy_control_reg u_dut (.*);
  neg_engine_model u_far (.*);
  always #25 SYS_CLK = ~SYS_CLK;
  // Whole run needs about 120 cycles
  always @(posedge SYS_CLK) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      bad_count = bad_count + 1;
      summarize;
    end
  end
  task summarize;
    begin
      $display("checks=%0d errors=%0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wt(input integer n);
    begin
      repeat (n) @(posedge SYS_CLK);
      #1;
    end
  endtask
  // Read data taken at the edge that sees waitrequest low
  task bus(input wr, input [7:0] a, input [15:0] d);
    begin
      @(posedge SYS_CLK);
      AVS_ADDRESS <= a;
      AVS_WRITEDATA <= {16'h0000, d};
      AVS_WRITE <= wr;
      AVS_READ <= !wr;
      do @(posedge SYS_CLK); while (AVS_WAITREQUEST !== 1'b0);
      rd = AVS_READDATA[15:0];
      AVS_WRITE <= 1'b0;
      AVS_READ <= 1'b0;
    end
  endtask
  function [15:0] exp_outs(input [15:0] v);
    reg spd, dup;
    begin
      spd = v[7] ? !fail_mode : v[6];
      dup = (!v[7] || fail_mode) ? v[5] : 1'b1;
      exp_outs = {3'h0, v[14], v[11], v[10], v[10] & v[9], v[8], v[7],
                  spd, dup, v[4:0]};
    end
  endfunction
  task t_fields(input fm, input [15:0] v);
    reg [15:0] e;
    begin
      fail_mode <= fm;
      bus(1'b1, 8'h08, v);
      bus(1'b0, 8'h08, 16'h0);
      chk(rd, v);
      wt(1);
      e = exp_outs(v);
      chk({8'h0, outs[12:5]}, {8'h0, e[12:5]});
      chk({11'h0, outs[4:0]}, {11'h0, e[4:0]});
      // Status: failed, done, pending, crossed, duplex, speed
      bus(1'b0, 8'h10, 16'h0);
      chk(rd, {10'h000, fm, !fm, 1'b0, e[9], e[5], e[6]});
    end
  endtask
  // Each byte lane written alone leaves the other untouched
  task t_lanes;
    begin
      AVS_BYTEENABLE <= 4'h2;
      bus(1'b1, 8'h08, 16'h40ff);
      AVS_BYTEENABLE <= 4'h1;
      bus(1'b1, 8'h08, 16'hff1b);
      AVS_BYTEENABLE <= 4'h3;
      bus(1'b0, 8'h08, 16'h0);
      chk(rd, 16'h401b);
      chk({3'h0, outs}, exp_outs(16'h401b));
      bus(1'b1, 8'h08, 16'h009f);
    end
  endtask
  task t_blank;
    reg [3:0] d;
    begin
      bus(1'b1, 8'h08, 16'h809f);
      wt(3);
      chk(ind, 4'hf);
      bus(1'b1, 8'h08, 16'h009f);
      wt(3);
      d = INDICATOR_DRIVE;
      wt(1);
      chk(ind, d);
    end
  endtask
  task t_reneg;
    integer n;
    begin
      n = 0;
      bus(1'b1, 8'h08, 16'h209f);
      repeat (6) begin
        wt(1);
        n = n + RENEGOTIATE_REQUEST;
      end
      chk(n[15:0], 16'h0001);
      bus(1'b0, 8'h08, 16'h0);
      chk(rd, 16'h009f);
    end
  endtask
  initial begin
    repeat (16) @(posedge SYS_CLK);
    RSTN <= 1'b1;
    wt(3);
    bus(1'b0, 8'h08, 16'h0);
    chk(rd, 16'h009f);
    chk({3'h0, outs}, exp_outs(16'h009f));
    t_blank;
    t_reneg;
    // Unmapped place: write ignored, reads zero
    bus(1'b1, 8'h0c, 16'hffff);
    bus(1'b0, 8'h0c, 16'h0);
    chk(rd, 16'h0000);
    bus(1'b0, 8'h08, 16'h0);
    chk(rd, 16'h009f);
    t_lanes;
    t_fields(1'b0, 16'h4e00);
    t_fields(1'b0, 16'h0260);
    t_fields(1'b0, 16'h0195);
    t_fields(1'b1, 16'h018a);
    t_fields(1'b1, 16'h10bf);
    summarize;
  end
endmodule // port_phy_control_reg_tb_top
